// ==== hw/dso_pkg.sv ====
// Constants and types for the drive status output selector
// Function
// - Item 12: run command and output active
// - Item 13: stopped with no run command
// - Item 14: running at constant speed
// - Item 0: commanded near actual frequency
// - Item 1: command equals level, item 0
// - Item 2: running frequency near detection level
// - Item 3: level detect with decel hysteresis
// - Item 4: item 3 condition, inverted
// - Item 8: over-voltage trip
// - Item 9: low-voltage trip
// - Item 10: heatsink overheat
// - Item 11: command inputs lost
// - Item 16: waiting for run command
// - Item 17: output follows fault mask
// - Mask bits: low-voltage, other trip, restart
// - Item 18: fan trip when continuing
// - Level, bandwidth limited by maximum frequency when written
// - Separate terminal and relay selectors
package dso_pkg;
    localparam int ADDR_W = 5;
    localparam int SEL_W = 5;
    localparam int ITEM_COUNT = 19;
    localparam logic [4:0] OFF_LEVEL = 5'h00;
    localparam logic [4:0] OFF_BANDWIDTH = 5'h04;
    localparam logic [4:0] OFF_FAULT_MASK = 5'h08;
    localparam logic [4:0] OFF_TERM_SEL = 5'h0c;
    localparam logic [4:0] OFF_RELAY_SEL = 5'h10;
    localparam logic [4:0] OFF_MAX_FREQ = 5'h14;
    localparam logic [4:0] OFF_FAN_HANDLING = 5'h18;
    localparam logic [4:0] OFF_STATUS = 5'h1c;
    // 400.00 Hz in hundredths
    localparam logic [15:0] FREQ_LIMIT = 16'h9c40;
    localparam logic [15:0] RST_LEVEL = 16'h0bb8;
    localparam logic [15:0] RST_BANDWIDTH = 16'h03e8;
    localparam logic [15:0] RST_MAX_FREQ = 16'h9c40;
    localparam logic [2:0] RST_FAULT_MASK = 3'h2;
    localparam logic [4:0] RST_TERM_SEL = 5'h0c;
    localparam logic [4:0] RST_RELAY_SEL = 5'h11;
    localparam logic RST_FAN_HANDLING = 1'b0;
    localparam logic [4:0] ITEM_MAX = 5'h12;
    localparam logic [4:0] ITEM_SPEED_REACHED = 5'h00;
    localparam logic [4:0] ITEM_RUN = 5'h0c;
    localparam logic [4:0] ITEM_STOP = 5'h0d;
    localparam logic [4:0] ITEM_CONST = 5'h0e;
    localparam logic [4:0] ITEM_FAULT = 5'h11;
    localparam logic [4:0] ITEM_FAN = 5'h12;
    localparam int STAT_TERM_BIT = 24;
    localparam int STAT_RELAY_BIT = 25;
    typedef enum logic [1:0] {
        DSO_IDLE = 2'b00,
        DSO_ACK = 2'b01
    } dso_state_t;
endpackage : dso_pkg

// ==== hw/dso_top.sv ====
// Status source selection for output terminal and relay, Avalon slave
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
module dso_top (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [4:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic [15:0] CMD_FREQ,
    input wire logic [15:0] OUT_FREQ,
    input wire logic RUN_CMD,
    input wire logic OUTPUT_ACTIVE,
    input wire logic ACCEL,
    input wire logic DECEL,
    input wire logic MOTOR_OVERLOAD,
    input wire logic DRIVE_OVERLOAD,
    input wire logic MOTOR_STALL,
    input wire logic TRIP_OVER_VOLTAGE,
    input wire logic TRIP_LOW_VOLTAGE,
    input wire logic TRIP_OTHER,
    input wire logic HEATSINK_OVERHEAT,
    input wire logic COMMAND_LOSS,
    input wire logic SPEED_SEARCH,
    input wire logic WAIT_RUN,
    input wire logic RESTARTING,
    input wire logic FAN_TRIP,
    output logic OPEN_COLLECTOR_OUTPUT,
    output logic RELAY_OUTPUT
);
    dso_pkg::dso_state_t st_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [15:0] level_r;
    logic [15:0] bw_r;
    logic [15:0] max_freq_r;
    logic [2:0] mask_r;
    logic [4:0] term_sel_r;
    logic [4:0] relay_sel_r;
    logic fan_handling_r;
    logic above_r;
    logic term_out_r;
    logic relay_out_r;
    logic [dso_pkg::ITEM_COUNT-1:0] item_vec;
    logic [15:0] half_bw;
    logic [15:0] low_thresh;
    logic [15:0] level_nxt;
    logic [15:0] bw_nxt;
    logic [15:0] max_nxt;
    logic wr_go;
    logic fault_any;
    logic [31:0] read_mux;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic [15:0] absdiff(input logic [15:0] a,
        input logic [15:0] b);
        absdiff = (a >= b) ? a - b : b - a;
    endfunction : absdiff

    function automatic logic pick(input logic [dso_pkg::ITEM_COUNT-1:0] v,
        input logic [4:0] sel);
        pick = (sel <= dso_pkg::ITEM_MAX) ? v[sel] : 1'b0;
    endfunction : pick

    // Bus: one wait cycle, then the access completes
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            st_r <= dso_pkg::DSO_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            unique case (st_r)
                dso_pkg::DSO_IDLE: begin
                    if (READ || WRITE) begin
                        st_r <= dso_pkg::DSO_ACK;
                        wait_r <= 1'b0;
                        rdata_r <= READ ? read_mux : 32'h0;
                    end
                end
                dso_pkg::DSO_ACK: begin
                    st_r <= dso_pkg::DSO_IDLE;
                    wait_r <= 1'b1;
                end
                default: begin
                    st_r <= dso_pkg::DSO_IDLE;
                    wait_r <= 1'b1;
                end
            endcase
        end
    end

    // Bus handshake: answer one cycle after a request is taken
    bus_answer_a: assert property (@(posedge CLOCK) disable iff (RESET)
        st_r == dso_pkg::DSO_IDLE && (READ || WRITE) |=> !WAITREQUEST)
        else $error("request not answered in next cycle");
    wait_pulse_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !WAITREQUEST |=> WAITREQUEST)
        else $error("waitrequest low longer than one cycle");

    assign wr_go = (st_r == dso_pkg::DSO_ACK) && WRITE;
    assign level_nxt = merge16(level_r, WRITEDATA, BYTEENABLE);
    assign bw_nxt = merge16(bw_r, WRITEDATA, BYTEENABLE);
    assign max_nxt = merge16(max_freq_r, WRITEDATA, BYTEENABLE);

    always_comb begin
        read_mux = 32'h0;
        if (hit(ADDRESS, dso_pkg::OFF_LEVEL)) begin
            read_mux[15:0] = level_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_BANDWIDTH)) begin
            read_mux[15:0] = bw_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_FAULT_MASK)) begin
            read_mux[2:0] = mask_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_TERM_SEL)) begin
            read_mux[4:0] = term_sel_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_RELAY_SEL)) begin
            read_mux[4:0] = relay_sel_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_MAX_FREQ)) begin
            read_mux[15:0] = max_freq_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_FAN_HANDLING)) begin
            read_mux[0] = fan_handling_r;
        end else if (hit(ADDRESS, dso_pkg::OFF_STATUS)) begin
            read_mux[dso_pkg::ITEM_COUNT-1:0] = item_vec;
            read_mux[dso_pkg::STAT_TERM_BIT] = term_out_r;
            read_mux[dso_pkg::STAT_RELAY_BIT] = relay_out_r;
        end
    end

    // Out-of-range settings are dropped whole, old value stays
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            level_r <= dso_pkg::RST_LEVEL;
        end else if (wr_go && hit(ADDRESS, dso_pkg::OFF_LEVEL) &&
                     level_nxt <= max_freq_r) begin
            level_r <= level_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            bw_r <= dso_pkg::RST_BANDWIDTH;
        end else if (wr_go && hit(ADDRESS, dso_pkg::OFF_BANDWIDTH) &&
                     bw_nxt <= max_freq_r) begin
            bw_r <= bw_nxt;
        end
    end

    // Lowering the maximum does not clip level or bandwidth already set
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            max_freq_r <= dso_pkg::RST_MAX_FREQ;
        end else if (wr_go && hit(ADDRESS, dso_pkg::OFF_MAX_FREQ) &&
                     max_nxt <= dso_pkg::FREQ_LIMIT) begin
            max_freq_r <= max_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            mask_r <= dso_pkg::RST_FAULT_MASK;
        end else if (wr_go && hit(ADDRESS, dso_pkg::OFF_FAULT_MASK) &&
                     BYTEENABLE[0]) begin
            mask_r <= WRITEDATA[2:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            term_sel_r <= dso_pkg::RST_TERM_SEL;
            relay_sel_r <= dso_pkg::RST_RELAY_SEL;
        end else if (wr_go && BYTEENABLE[0] &&
                     WRITEDATA[4:0] <= dso_pkg::ITEM_MAX &&
                     WRITEDATA[7:5] == 3'h0) begin
            if (hit(ADDRESS, dso_pkg::OFF_TERM_SEL)) begin
                term_sel_r <= WRITEDATA[4:0];
            end
            if (hit(ADDRESS, dso_pkg::OFF_RELAY_SEL)) begin
                relay_sel_r <= WRITEDATA[4:0];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            fan_handling_r <= dso_pkg::RST_FAN_HANDLING;
        end else if (wr_go && hit(ADDRESS, dso_pkg::OFF_FAN_HANDLING) &&
                     BYTEENABLE[0]) begin
            fan_handling_r <= WRITEDATA[0];
        end
    end

    // Settings never leave the 0 to 400 Hz span
    reject_bw_a: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_go && hit(ADDRESS, dso_pkg::OFF_BANDWIDTH) && bw_nxt > max_freq_r
        |=> $stable(bw_r))
        else $error("bandwidth above maximum accepted");
    reject_max_a: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_go && hit(ADDRESS, dso_pkg::OFF_MAX_FREQ) &&
        max_nxt > dso_pkg::FREQ_LIMIT |=> $stable(max_freq_r))
        else $error("maximum frequency above limit accepted");
    freq_limit_a: assert property (@(posedge CLOCK) disable iff (RESET)
        level_r <= dso_pkg::FREQ_LIMIT && bw_r <= dso_pkg::FREQ_LIMIT &&
        max_freq_r <= dso_pkg::FREQ_LIMIT)
        else $error("stored frequency above 400 Hz");
    sel_range_a: assert property (@(posedge CLOCK) disable iff (RESET)
        term_sel_r <= dso_pkg::ITEM_MAX && relay_sel_r <= dso_pkg::ITEM_MAX)
        else $error("selector outside item list");
    sel_apart_a: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_go && hit(ADDRESS, dso_pkg::OFF_TERM_SEL) |=> $stable(relay_sel_r))
        else $error("relay selector moved by terminal write");
    mask_write_a: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_go && hit(ADDRESS, dso_pkg::OFF_FAULT_MASK) && BYTEENABLE[0]
        |=> mask_r == $past(WRITEDATA[2:0]))
        else $error("fault mask write lost");
    fan_write_a: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_go && hit(ADDRESS, dso_pkg::OFF_FAN_HANDLING) && BYTEENABLE[0]
        |=> fan_handling_r == $past(WRITEDATA[0]))
        else $error("fan handling write lost");

    // Frequencies are unsigned hundredths of a hertz
    assign half_bw = bw_r >> 1;
    // Saturate so a wide band cannot wrap below zero
    assign low_thresh = (level_r > half_bw) ? level_r - half_bw : 16'h0;

    // Constant speed holds the last decision
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            above_r <= 1'b0;
        end else if (ACCEL && !DECEL) begin
            above_r <= (OUT_FREQ >= level_r);
        end else if (DECEL && !ACCEL) begin
            above_r <= (OUT_FREQ > low_thresh);
        end
    end

    assign fault_any = (mask_r[0] && TRIP_LOW_VOLTAGE) ||
                       (mask_r[1] && TRIP_OTHER) ||
                       (mask_r[2] && RESTARTING);

    always_comb begin
        item_vec = '0;
        item_vec[0] = absdiff(CMD_FREQ, OUT_FREQ) <= half_bw;
        item_vec[1] = (CMD_FREQ == level_r) && item_vec[0];
        item_vec[2] = absdiff(level_r, OUT_FREQ) <= half_bw;
        item_vec[3] = above_r;
        item_vec[4] = !above_r;
        item_vec[5] = MOTOR_OVERLOAD;
        item_vec[6] = DRIVE_OVERLOAD;
        item_vec[7] = MOTOR_STALL;
        item_vec[8] = TRIP_OVER_VOLTAGE;
        item_vec[9] = TRIP_LOW_VOLTAGE;
        item_vec[10] = HEATSINK_OVERHEAT;
        item_vec[11] = COMMAND_LOSS;
        item_vec[12] = RUN_CMD && OUTPUT_ACTIVE;
        item_vec[13] = !RUN_CMD && !OUTPUT_ACTIVE;
        item_vec[14] = OUTPUT_ACTIVE && !ACCEL && !DECEL;
        item_vec[15] = SPEED_SEARCH;
        item_vec[16] = WAIT_RUN;
        item_vec[17] = fault_any;
        item_vec[18] = FAN_TRIP && !fan_handling_r;
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            term_out_r <= 1'b0;
            relay_out_r <= 1'b0;
        end else begin
            term_out_r <= pick(item_vec, term_sel_r);
            relay_out_r <= pick(item_vec, relay_sel_r);
        end
    end

    assign OPEN_COLLECTOR_OUTPUT = term_out_r;
    assign RELAY_OUTPUT = relay_out_r;
    assign READDATA = rdata_r;
    assign WAITREQUEST = wait_r;

    during_run_a: assert property (@(posedge CLOCK) disable iff (RESET)
        term_sel_r == dso_pkg::ITEM_RUN && $stable(term_sel_r) |->
        OPEN_COLLECTOR_OUTPUT == $past(RUN_CMD && OUTPUT_ACTIVE))
        else $error("run item mismatch");
    during_stop_a: assert property (@(posedge CLOCK) disable iff (RESET)
        relay_sel_r == dso_pkg::ITEM_STOP && $stable(relay_sel_r) |->
        RELAY_OUTPUT == $past(!RUN_CMD && !OUTPUT_ACTIVE))
        else $error("stop item mismatch");
    const_run_a: assert property (@(posedge CLOCK) disable iff (RESET)
        (ACCEL || DECEL) && term_sel_r == dso_pkg::ITEM_CONST ##1
        $stable(term_sel_r) |-> !OPEN_COLLECTOR_OUTPUT)
        else $error("constant run while ramping");
    speed_reach_a: assert property (@(posedge CLOCK) disable iff (RESET)
        term_sel_r == dso_pkg::ITEM_SPEED_REACHED ##1 $stable(term_sel_r)
        |-> OPEN_COLLECTOR_OUTPUT == ($past(absdiff(CMD_FREQ, OUT_FREQ))
        <= $past(bw_r >> 1)))
        else $error("speed reached mismatch");
    level_speed_a: assert property (@(posedge CLOCK) disable iff (RESET)
        item_vec[1] |-> item_vec[2])
        else $error("level and speed item without level window");
    hyst_accel_a: assert property (@(posedge CLOCK) disable iff (RESET)
        ACCEL && !DECEL && OUT_FREQ >= level_r |=> item_vec[3])
        else $error("level not detected in accel");
    hyst_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !ACCEL && !DECEL |=> $stable(above_r))
        else $error("hysteresis state changed at constant speed");
    item_invert_a: assert property (@(posedge CLOCK) disable iff (RESET)
        DECEL && !ACCEL &&
        {1'b0, OUT_FREQ} + {1'b0, bw_r[15:1]} <= {1'b0, level_r}
        |=> item_vec[4])
        else $error("inverted item not set below window");
    fault_mask_a: assert property (@(posedge CLOCK) disable iff (RESET)
        relay_sel_r == dso_pkg::ITEM_FAULT && mask_r == 3'h0 ##1
        $stable(relay_sel_r) |-> !RELAY_OUTPUT)
        else $error("fault out with empty mask");
    fan_alarm_a: assert property (@(posedge CLOCK) disable iff (RESET)
        fan_handling_r && term_sel_r == dso_pkg::ITEM_FAN ##1
        $stable(term_sel_r) |-> !OPEN_COLLECTOR_OUTPUT)
        else $error("fan alarm while stopping");
    level_cap_a: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_go && hit(ADDRESS, dso_pkg::OFF_LEVEL) && level_nxt > max_freq_r
        |=> $stable(level_r))
        else $error("level above maximum accepted");

    // Cross-checks between items, not copies of their logic
    near_level_a: assert property (@(posedge CLOCK) disable iff (RESET)
        {1'b0, OUT_FREQ} + {1'b0, bw_r[15:1]} < {1'b0, level_r} |->
        !item_vec[2])
        else $error("level window item set while far away");
    hyst_decel_a: assert property (@(posedge CLOCK) disable iff (RESET)
        DECEL && !ACCEL && OUT_FREQ > level_r |=> item_vec[3])
        else $error("level lost in decel above level");
    ramp_both_a: assert property (@(posedge CLOCK) disable iff (RESET)
        ACCEL && DECEL |=> $stable(above_r))
        else $error("hysteresis state changed with both ramps");
    term_pick_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !$past(RESET) && $stable(term_sel_r) |->
        OPEN_COLLECTOR_OUTPUT == $past(item_vec[term_sel_r]))
        else $error("terminal output not the selected item");
    relay_pick_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !$past(RESET) && $stable(relay_sel_r) |->
        RELAY_OUTPUT == $past(item_vec[relay_sel_r]))
        else $error("relay output not the selected item");
    run_stop_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !(item_vec[12] && item_vec[13]))
        else $error("running and stopped together");
    const_item_a: assert property (@(posedge CLOCK) disable iff (RESET)
        OUTPUT_ACTIVE && !ACCEL && !DECEL |-> item_vec[14])
        else $error("constant run item missing");
    wait_item_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WAIT_RUN |-> item_vec[16])
        else $error("wait item missing");
    low_mask_a: assert property (@(posedge CLOCK) disable iff (RESET)
        mask_r[0] && TRIP_LOW_VOLTAGE |-> item_vec[17])
        else $error("masked low-voltage trip not reported");
    retry_mask_a: assert property (@(posedge CLOCK) disable iff (RESET)
        mask_r[2] && RESTARTING |-> item_vec[17])
        else $error("masked restart not reported");
    no_fault_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !TRIP_LOW_VOLTAGE && !TRIP_OTHER && !RESTARTING |-> !item_vec[17])
        else $error("fault output without a cause");
    fan_raise_a: assert property (@(posedge CLOCK) disable iff (RESET)
        FAN_TRIP && !fan_handling_r |-> item_vec[18])
        else $error("fan alarm missing while continuing");
endmodule : dso_top

// ==== bench/dso_load.sv ====
// Far-side load: pulled-up collector line and relay contact
module dso_load (
    input wire logic oc_on,
    input wire logic relay_on,
    output logic line_level,
    output logic contact_made
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up shows high whenever the transistor is off
    assign line_level = oc_on ? 1'b0 : 1'b1;
    assign contact_made = relay_on;
endmodule : dso_load

// ==== bench/tb_drive_status_output_select.sv ====
// Self-checking bench for the drive status output selector
module tb_drive_status_output_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK, RESET, READ, WRITE, WAITREQUEST;
    logic OPEN_COLLECTOR_OUTPUT, RELAY_OUTPUT, line_level, contact_made;
    logic [4:0] ADDRESS, tsel, rsel;
    logic [3:0] BYTEENABLE;
    logic [31:0] WRITEDATA, READDATA, rd;
    logic [15:0] cmd, outf, lvl, bw, f;
    logic [2:0] msk;
    logic fan, hy;
    int error_cnt = 0;
    int tests_run = 0;
    logic [4:0] offs [8] = '{dso_pkg::OFF_LEVEL, dso_pkg::OFF_BANDWIDTH,
        dso_pkg::OFF_FAULT_MASK, dso_pkg::OFF_TERM_SEL, dso_pkg::OFF_RELAY_SEL,
        dso_pkg::OFF_MAX_FREQ, dso_pkg::OFF_FAN_HANDLING, 5'h02};
    logic [31:0] rv [8] = '{32'h0bb8, 32'h03e8, 32'h2, 32'hc, 32'h11,
        32'h9c40, 32'h0, 32'h0};
    logic [15:0] fl3 [3] = '{16'h0100, 16'h0200, 16'h4000};

    dso_top dut (.CLOCK(CLOCK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CMD_FREQ(cmd),
        .OUT_FREQ(outf), .RUN_CMD(f[0]), .OUTPUT_ACTIVE(f[1]), .ACCEL(f[2]),
        .DECEL(f[3]), .MOTOR_OVERLOAD(f[4]), .DRIVE_OVERLOAD(f[5]),
        .MOTOR_STALL(f[6]), .TRIP_OVER_VOLTAGE(f[7]), .TRIP_LOW_VOLTAGE(f[8]),
        .TRIP_OTHER(f[9]), .HEATSINK_OVERHEAT(f[10]), .COMMAND_LOSS(f[11]),
        .SPEED_SEARCH(f[12]), .WAIT_RUN(f[13]), .RESTARTING(f[14]),
        .FAN_TRIP(f[15]), .OPEN_COLLECTOR_OUTPUT(OPEN_COLLECTOR_OUTPUT),
        .RELAY_OUTPUT(RELAY_OUTPUT));
    dso_load load (.oc_on(OPEN_COLLECTOR_OUTPUT), .relay_on(RELAY_OUTPUT),
        .line_level(line_level), .contact_made(contact_made));

    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Request held until waitrequest seen low, then released
    task automatic bus(input logic w, input logic [4:0] a,
            input logic [31:0] d, input logic [3:0] be);
        @(posedge CLOCK);
        ADDRESS <= a;
        WRITE <= w;
        READ <= ~w;
        WRITEDATA <= d;
        BYTEENABLE <= be;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge CLOCK);
        end while (WAITREQUEST !== 1'b0);
        rd = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask : bus

    task automatic wrchk(input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] be, input logic [31:0] x);
        bus(1'b1, a, d, be);
        bus(1'b0, a, 32'h0, 4'h0);
        chk(rd, x);
    endtask : wrchk

    function automatic logic [18:0] items();
        logic [15:0] h, d0, d2;
        h = bw >> 1;
        d0 = cmd > outf ? cmd - outf : outf - cmd;
        d2 = lvl > outf ? lvl - outf : outf - lvl;
        return {f[15] & !fan,
            (msk[0] & f[8]) | (msk[1] & f[9]) | (msk[2] & f[14]),
            f[13], f[12], f[1] & !f[2] & !f[3], !f[0] & !f[1], f[0] & f[1],
            f[11], f[10], f[8], f[7], f[6], f[5], f[4], !hy, hy,
            d2 <= h, cmd == lvl && d0 <= h, d0 <= h};
    endfunction : items

    task automatic set_in(input logic [15:0] c, o, fl);
        logic [15:0] h;
        h = bw >> 1;
        @(posedge CLOCK);
        cmd <= c;
        outf <= o;
        f <= fl;
        repeat (3) @(posedge CLOCK);
        if (fl[2] && !fl[3]) hy = o >= lvl;
        else if (fl[3] && !fl[2]) hy = o > ((lvl > h) ? lvl - h : 16'h0);
    endtask : set_in

    task automatic chkall();
        logic [18:0] e;
        e = items();
        bus(1'b0, dso_pkg::OFF_STATUS, 32'h0, 4'h0);
        chk(32'({rd[25:24], rd[18:0]}), 32'({e[rsel], e[tsel], e}));
        chk(32'({line_level, contact_made}), 32'({!e[tsel], e[rsel]}));
    endtask : chkall

    task automatic sweep(input logic [15:0] c, o, fl);
        set_in(c, o, fl);
        for (int k = 0; k <= 18; k++) begin
            tsel = 5'(k);
            rsel = 5'(18 - k);
            bus(1'b1, dso_pkg::OFF_TERM_SEL, 32'(tsel), 4'h1);
            bus(1'b1, dso_pkg::OFF_RELAY_SEL, 32'(rsel), 4'h1);
            chkall();
        end
    endtask : sweep

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge CLOCK);
        error_cnt++;
        close_out();
    end

    initial begin
        RESET = 1'b1;
        READ = 1'b0;
        WRITE = 1'b0;
        ADDRESS = 5'h0;
        BYTEENABLE = 4'h0;
        WRITEDATA = 32'h0;
        cmd = 16'h0;
        outf = 16'h0;
        f = 16'h0;
        lvl = 16'h0bb8;
        bw = 16'h03e8;
        msk = 3'h2;
        fan = 1'b0;
        hy = 1'b0;
        tsel = 5'h0c;
        rsel = 5'h11;
        repeat (16) @(posedge CLOCK);
        RESET <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, offs[i], 32'h0, 4'h0);
            chk(rd, rv[i]);
        end
        chkall();
        $display("test reset done");
        set_in(16'h0bb8, 16'h09c4, 16'h0007);
        chkall();
        set_in(16'h0bb8, 16'h09c3, 16'h0007);
        chkall();
        set_in(16'h0bb8, 16'h0bb8, 16'h0007);
        chkall();
        set_in(16'h0bb8, 16'h0dac, 16'h000b);
        chkall();
        set_in(16'h0bb8, 16'h0a28, 16'h000b);
        chkall();
        set_in(16'h0bb8, 16'h09c4, 16'h000b);
        chkall();
        set_in(16'h0bb8, 16'h0a28, 16'h000f);
        chkall();
        set_in(16'h0bb8, 16'h0dac, 16'h0002);
        chkall();
        sweep(16'h0bb8, 16'h0bb8, 16'h5555);
        sweep(16'h0100, 16'h0200, 16'haaaa);
        $display("test frequency and items done");
        tsel = 5'h11;
        bus(1'b1, dso_pkg::OFF_TERM_SEL, 32'h11, 4'h1);
        for (int i = 0; i < 8; i++) begin
            msk = 3'(i);
            bus(1'b1, dso_pkg::OFF_FAULT_MASK, 32'(i), 4'h1);
            for (int j = 0; j < 3; j++) begin
                set_in(cmd, outf, fl3[j]);
                chkall();
            end
        end
        $display("test fault mask done");
        wrchk(dso_pkg::OFF_LEVEL, 32'h9c41, 4'h3, 32'h0bb8);
        wrchk(dso_pkg::OFF_MAX_FREQ, 32'h9c41, 4'h3, 32'h9c40);
        wrchk(dso_pkg::OFF_MAX_FREQ, 32'h07d0, 4'h3, 32'h07d0);
        wrchk(dso_pkg::OFF_BANDWIDTH, 32'h07d1, 4'h3, 32'h03e8);
        wrchk(dso_pkg::OFF_BANDWIDTH, 32'h07d0, 4'h3, 32'h07d0);
        bw = 16'h07d0;
        wrchk(dso_pkg::OFF_MAX_FREQ, 32'h9c40, 4'h3, 32'h9c40);
        wrchk(dso_pkg::OFF_LEVEL, 32'hff10, 4'h1, 32'h0b10);
        lvl = 16'h0b10;
        wrchk(dso_pkg::OFF_RELAY_SEL, 32'h13, 4'h1, 32'(rsel));
        wrchk(dso_pkg::OFF_FAULT_MASK, 32'h5, 4'h0, 32'(msk));
        wrchk(5'h02, 32'hffff, 4'hf, 32'h0);
        tsel = dso_pkg::ITEM_FAN;
        bus(1'b1, dso_pkg::OFF_TERM_SEL, 32'(tsel), 4'h1);
        set_in(16'h0b10, 16'h0b10, 16'h8003);
        chkall();
        wrchk(dso_pkg::OFF_FAN_HANDLING, 32'h1, 4'h1, 32'h1);
        fan = 1'b1;
        chkall();
        $display("test settings done");
        close_out();
    end
endmodule : tb_drive_status_output_select
